// ### shared/cswb_pkg.sv
package cswb_pkg;
	localparam int          CSWB_NSEL      = 4;
	// register byte offsets, four words per select block
	localparam logic [7:0]  CSWB_OFS_CTL   = 8'h00;
	localparam logic [7:0]  CSWB_OFS_LBR   = 8'h04;
	localparam logic [7:0]  CSWB_OFS_UBR   = 8'h08;
	localparam logic [7:0]  CSWB_OFS_MODE  = 8'h0c;
	localparam logic [7:0]  CSWB_OFS_STAT  = 8'h40;
	localparam int          CSWB_BLK_SH    = 4;
	// control field positions
	localparam int          CSWB_EN_BIT    = 3;
	localparam int          CSWB_IO_BIT    = 4;
	localparam int          CSWB_WAIT_LSB  = 5;
	// mode register fields: bits 1:0 mode, 7:4 clocks per state
	localparam int          CSWB_CPS_LSB   = 4;
	localparam logic [1:0]  CSWB_MODE_NAT  = 2'h0;
	localparam logic [1:0]  CSWB_MODE_LEG  = 2'h1;
	// reset values
	localparam logic [7:0]  CSWB_CTL_RST   = 8'h00;
	localparam logic [7:0]  CSWB_LBR_RST   = 8'h00;
	localparam logic [7:0]  CSWB_UBR0_RST  = 8'hff;
	localparam logic [7:0]  CSWB_UBR_RST   = 8'h00;
	localparam logic [7:0]  CSWB_MODE_RST  = 8'h10;
	// on-chip peripheral I/O window
	localparam logic [15:0] CSWB_PERI_LO   = 16'h0080;
	localparam logic [15:0] CSWB_PERI_HI   = 16'h00ff;
	localparam logic [1:0]  CSWB_RESP_OK   = 2'h0;
	localparam logic [1:0]  CSWB_RESP_ERR  = 2'h2;
	typedef enum logic [1:0] {
		CSWB_T_IDLE = 2'h0,
		CSWB_T_1    = 2'h1,
		CSWB_T_2    = 2'h2,
		CSWB_T_3    = 2'h3
	} cswb_tst_e;
endpackage : cswb_pkg

// ### hdl/cswb_ctrl.sv
// Our own choices: the register offsets and register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
module cswb_ctrl
	import cswb_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_i,
	// axi4-lite write address and data
	input  wire logic        s_axi_awvalid_i,
	output logic             s_axi_awready_o,
	input  wire logic [7:0]  s_axi_awaddr_i,
	input  wire logic        s_axi_wvalid_i,
	output logic             s_axi_wready_o,
	input  wire logic [31:0] s_axi_wdata_i,
	input  wire logic [3:0]  s_axi_wstrb_i,
	// axi4-lite write response
	output logic             s_axi_bvalid_o,
	input  wire logic        s_axi_bready_i,
	output logic [1:0]       s_axi_bresp_o,
	// axi4-lite read
	input  wire logic        s_axi_arvalid_i,
	output logic             s_axi_arready_o,
	input  wire logic [7:0]  s_axi_araddr_i,
	output logic             s_axi_rvalid_o,
	input  wire logic        s_axi_rready_i,
	output logic [31:0]      s_axi_rdata_o,
	output logic [1:0]       s_axi_rresp_o,
	// cpu side access
	input  wire logic [23:0] cpu_addr_i,
	input  wire logic        cpu_mem_cycle_i,
	input  wire logic        cpu_io_cycle_i,
	input  wire logic        cpu_rd_i,
	input  wire logic        cpu_wr_i,
	output logic             cpu_stall_o,
	output logic [7:0]       cpu_rdata_o,
	// external bus
	input  wire logic [23:0] ext_addr_i,
	input  wire logic [7:0]  ext_data_i,
	input  wire logic        ext_wait_n_i,
	input  wire logic        bus_takeover_request_n_i,
	output logic             bus_grant_n_o,
	output logic             addr_oe_o,
	output logic [3:0]       select_line_n_o,
	output logic             memory_request_n_o,
	output logic             port_request_n_o,
	output logic             rd_n_o,
	output logic             wr_n_o
);
	//------------------------------------------------------------
	// state
	//------------------------------------------------------------
	typedef struct packed {
		// software-visible registers, one byte per select each
		logic [3:0][7:0] ctl;
		logic [3:0][7:0] lbr;
		logic [3:0][7:0] ubr;
		logic [3:0][7:0] mode;
		// axi write side: address and data may arrive apart
		logic            aw_got;
		logic            w_got;
		logic [7:0]      aw_addr;
		logic [31:0]     wdata;
		logic [3:0]      wstrb;
		// answers held until the master takes them
		logic            bvalid;
		logic [1:0]      bresp;
		logic            rvalid;
		logic [31:0]     rdata;
		logic [1:0]      rresp;
		// access sequencing: legacy state, state and wait counters
		cswb_tst_e       tst;
		logic [3:0]      tcnt;
		logic [2:0]      wcnt;
		logic            wait_done;
		// wait input one sample back, so a wait is honoured one cycle past its release
		logic            ext_hold;
		logic [7:0]      rlatch;
		// takeover grant and activity flag for the status register
		logic            grant;
		logic            busy;
	} cswb_st_s;

	cswb_st_s st_ff;
	cswb_st_s nxt_st;

	//------------------------------------------------------------
	// elaboration checks
	//------------------------------------------------------------
	// the select pins, the packed register arrays and the two-bit
	// winner index are all sized for four selects
	if (CSWB_NSEL != 4) begin : g_nsel_chk
		$error("cswb_ctrl serves exactly four selects");
	end

	//------------------------------------------------------------
	// helpers
	//------------------------------------------------------------
	// register index from byte address, -1 style flag in bit 5
	function automatic logic [5:0] cswb_dec(input logic [7:0] a);
		logic [5:0] r;
		r = 6'h20;
		if (a[7:6] == 2'h0 && a[1:0] == 2'h0)
			r = {2'h0, a[5:2]};
		else if (a == CSWB_OFS_STAT)
			r = 6'h10;
		return r;
	endfunction : cswb_dec

	// byte merge under the lane strobe; upper lanes are ignored
	function automatic logic [7:0] cswb_mrg(input logic [7:0] o,
		input logic [7:0] d, input logic s);
		return s ? d : o;
	endfunction : cswb_mrg

	//------------------------------------------------------------
	// select decode
	//------------------------------------------------------------
	// decode is purely combinational so a native access sees its
	// select in the same cycle the cpu presents the address
	logic [23:0] dec_addr;
	logic [3:0]  hit;
	logic [3:0]  win;
	logic [1:0]  win_idx;
	logic        any_win;
	logic        peri_io;

	// during takeover the external master's address is decoded
	assign dec_addr = st_ff.grant ? ext_addr_i : cpu_addr_i;
	assign peri_io  = dec_addr[15:0] >= CSWB_PERI_LO
		&& dec_addr[15:0] <= CSWB_PERI_HI;

	// raw match per select; the space bit steers each select to one
	// kind of cycle only, so a select never answers both spaces
	// and an I/O match ignores the page byte entirely
	always_comb begin
		for (int i = 0; i < CSWB_NSEL; i++) begin
			hit[i] = 1'b0;
			if (st_ff.ctl[i][CSWB_EN_BIT]) begin
				if (!st_ff.ctl[i][CSWB_IO_BIT])
					hit[i] = cpu_mem_cycle_i
						&& st_ff.lbr[i] <= dec_addr[23:16]
						&& dec_addr[23:16] <= st_ff.ubr[i];
				else
					hit[i] = cpu_io_cycle_i && !peri_io
						&& dec_addr[15:8] == st_ff.lbr[i];
			end
		end
	end

	// lowest number wins; one-hot keeps one select low per access
	always_comb begin
		win     = 4'h0;
		win_idx = 2'h0;
		for (int i = CSWB_NSEL - 1; i >= 0; i--) begin
			if (hit[i]) begin
				win     = 4'h0;
				win[i]  = 1'b1;
				win_idx = i[1:0];
			end
		end
	end
	assign any_win = |win;

	// timing fields of the winning select, used by both sequencers
	logic [1:0] sel_mode;
	logic [3:0] sel_cps;
	logic [2:0] sel_wait;
	logic       acc;
	assign sel_mode = st_ff.mode[win_idx][1:0];
	assign sel_cps  = st_ff.mode[win_idx][7:CSWB_CPS_LSB];
	assign sel_wait = st_ff.ctl[win_idx][7:CSWB_WAIT_LSB];
	assign acc      = any_win && (cpu_rd_i || cpu_wr_i);

	//------------------------------------------------------------
	// next state
	//------------------------------------------------------------
	// register index of the held write and of the offered read
	logic [5:0] wdec;
	logic [5:0] rdec;
	logic       legacy;
	logic       state_end;
	assign wdec      = cswb_dec(st_ff.aw_addr);
	assign rdec      = cswb_dec(s_axi_araddr_i);
	assign legacy    = acc && sel_mode == CSWB_MODE_LEG;
	assign state_end = st_ff.tcnt <= 4'h1;

	always_comb begin
		nxt_st = st_ff;
		// bus takeover grant follows the request
		nxt_st.grant = !bus_takeover_request_n_i;

		// write channel: address and data in either order
		// a write only commits once both halves are held, so a
		// half-taken write can never reach the registers
		if (s_axi_awvalid_i && !st_ff.aw_got) begin
			nxt_st.aw_got  = 1'b1;
			nxt_st.aw_addr = s_axi_awaddr_i;
		end
		if (s_axi_wvalid_i && !st_ff.w_got) begin
			nxt_st.w_got = 1'b1;
			nxt_st.wdata = s_axi_wdata_i;
			nxt_st.wstrb = s_axi_wstrb_i;
		end
		if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
			nxt_st.aw_got = 1'b0;
			nxt_st.w_got  = 1'b0;
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp  = CSWB_RESP_OK;
			if (wdec[5:4] == 2'h0) begin
				case (wdec[1:0])
				2'h0: nxt_st.ctl[wdec[3:2]] = cswb_mrg(st_ff.ctl[wdec[3:2]],
					st_ff.wdata[7:0], st_ff.wstrb[0]);
				2'h1: nxt_st.lbr[wdec[3:2]] = cswb_mrg(st_ff.lbr[wdec[3:2]],
					st_ff.wdata[7:0], st_ff.wstrb[0]);
				2'h2: nxt_st.ubr[wdec[3:2]] = cswb_mrg(st_ff.ubr[wdec[3:2]],
					st_ff.wdata[7:0], st_ff.wstrb[0]);
				default: nxt_st.mode[wdec[3:2]] = cswb_mrg(
					st_ff.mode[wdec[3:2]], st_ff.wdata[7:0],
					st_ff.wstrb[0]);
				endcase
			end else if (wdec != 6'h10) begin
				nxt_st.bresp = CSWB_RESP_ERR;
			end
		end
		if (st_ff.bvalid && s_axi_bready_i)
			nxt_st.bvalid = 1'b0;

		// read channel: one read at a time; arready stays low
		// until the answer is taken, which refuses a second read
		if (s_axi_arvalid_i && !st_ff.rvalid) begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp  = CSWB_RESP_OK;
			nxt_st.rdata  = 32'h0;
			if (rdec[5:4] == 2'h0) begin
				case (rdec[1:0])
				2'h0:    nxt_st.rdata[7:0] = st_ff.ctl[rdec[3:2]];
				2'h1:    nxt_st.rdata[7:0] = st_ff.lbr[rdec[3:2]];
				2'h2:    nxt_st.rdata[7:0] = st_ff.ubr[rdec[3:2]];
				default: nxt_st.rdata[7:0] = st_ff.mode[rdec[3:2]];
				endcase
			end else if (rdec == 6'h10) begin
				nxt_st.rdata[7:0] = {st_ff.grant, st_ff.busy,
					st_ff.tst, ~select_line_n_o};
			end else begin
				nxt_st.rresp = CSWB_RESP_ERR;
			end
		end
		if (st_ff.rvalid && s_axi_rready_i)
			nxt_st.rvalid = 1'b0;

		// external wait input, held to next edge after it rises
		nxt_st.ext_hold = !ext_wait_n_i;

		// access sequencing
		// a dropped access clears the state, wait counter and done flag, so an aborted
		// cycle leaves nothing behind for the next one; the cost
		// is that the cpu must hold its request until stall falls
		if (!acc) begin
			nxt_st.busy      = 1'b0;
			nxt_st.tst       = CSWB_T_IDLE;
			nxt_st.wait_done = 1'b0;
			nxt_st.wcnt      = 3'h0;
		end else if (legacy) begin
			nxt_st.busy = 1'b1;
			case (st_ff.tst)
			CSWB_T_IDLE: begin
				nxt_st.tst  = CSWB_T_1;
				nxt_st.tcnt = sel_cps;
			end
			// T1: select only, address settles
			CSWB_T_1: begin
				nxt_st.tcnt = st_ff.tcnt - 4'h1;
				if (state_end) begin
					nxt_st.tst  = CSWB_T_2;
					nxt_st.tcnt = sel_cps;
				end
			end
			// T2: read and request strobes on; the last cycle stretches while wait is low
			CSWB_T_2: begin
				if (!state_end)
					nxt_st.tcnt = st_ff.tcnt - 4'h1;
				else if (!ext_wait_n_i || st_ff.ext_hold) begin
					nxt_st.tcnt = 4'h1;
				end else begin
					nxt_st.tst  = CSWB_T_3;
					nxt_st.tcnt = sel_cps;
				end
			end
			// T3: nothing changes, data taken on the closing edge
			CSWB_T_3: begin
				nxt_st.tcnt = st_ff.tcnt - 4'h1;
				if (state_end) begin
					nxt_st.rlatch    = ext_data_i;
					nxt_st.tst       = CSWB_T_IDLE;
					nxt_st.wait_done = 1'b1;
				end
			end
			default: nxt_st.tst = CSWB_T_IDLE;
			endcase
			// a finished cycle parks until the cpu drops the access
			if (st_ff.wait_done)
				nxt_st.tst = CSWB_T_IDLE;
		end else begin
			// native mode: programmed waits then external waits
			// the wait input is only looked at once the programmed
			// count has run out, so no external wait comes before them
			nxt_st.busy = 1'b1;
			if (!st_ff.wait_done) begin
				if (st_ff.wcnt < sel_wait)
					nxt_st.wcnt = st_ff.wcnt + 3'h1;
				else if (ext_wait_n_i && !st_ff.ext_hold) begin
					nxt_st.wait_done = 1'b1;
					nxt_st.rlatch    = ext_data_i;
				end
			end
		end
	end

	//------------------------------------------------------------
	// registers
	//------------------------------------------------------------
	// reset loads constants only; select 0 alone spans the memory map
	always_ff @(posedge sys_clk_i or posedge rst_i) begin
		if (rst_i) begin
			st_ff        <= '0;
			st_ff.tst    <= CSWB_T_IDLE;
			for (int i = 0; i < CSWB_NSEL; i++) begin
				st_ff.ctl[i]  <= CSWB_CTL_RST;
				st_ff.lbr[i]  <= CSWB_LBR_RST;
				st_ff.ubr[i]  <= (i == 0) ? CSWB_UBR0_RST : CSWB_UBR_RST;
				st_ff.mode[i] <= CSWB_MODE_RST;
			end
		end else begin
			st_ff <= nxt_st;
		end
	end

	//------------------------------------------------------------
	// outputs
	//------------------------------------------------------------
	// strobes are combinational so native mode adds no delay; the
	// cost is that they follow cpu glitches straight to the pins
	logic sel_on;
	logic strb_on;
	// legacy: select from T1, read and request strobes from T2 on; write strobe never
	assign sel_on  = legacy ? (st_ff.tst != CSWB_T_IDLE) : acc;
	assign strb_on = legacy ? (st_ff.tst == CSWB_T_2 || st_ff.tst == CSWB_T_3)
		: acc;

	// idle or unmatched keeps every select high
	assign select_line_n_o    = sel_on ? ~win : 4'hf;
	assign memory_request_n_o = !(strb_on && cpu_mem_cycle_i);
	assign port_request_n_o   = !(strb_on && cpu_io_cycle_i);
	assign rd_n_o             = !(strb_on && cpu_rd_i);
	assign wr_n_o             = !(strb_on && cpu_wr_i && !legacy);
	assign cpu_stall_o        = acc && !st_ff.wait_done;
	assign cpu_rdata_o        = st_ff.rlatch;
	assign bus_grant_n_o      = !st_ff.grant;
	assign addr_oe_o          = !st_ff.grant;

	// ready is refused only while a word is held, never by bus waits
	// axi handshakes; registers unreachable from external bus
	assign s_axi_awready_o = !st_ff.aw_got;
	assign s_axi_wready_o  = !st_ff.w_got;
	assign s_axi_bvalid_o  = st_ff.bvalid;
	assign s_axi_bresp_o   = st_ff.bresp;
	assign s_axi_arready_o = !st_ff.rvalid;
	assign s_axi_rvalid_o  = st_ff.rvalid;
	assign s_axi_rdata_o   = st_ff.rdata;
	assign s_axi_rresp_o   = st_ff.rresp;
endmodule : cswb_ctrl
`default_nettype wire

// ### verification/cswb_monitor.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// port rule checker
// ----
module cswb_monitor
	import cswb_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk_i,
	input wire logic        rst_i,
	// cpu and external inputs
	input wire logic [23:0] cpu_addr_i,
	input wire logic        cpu_mem_cycle_i,
	input wire logic        cpu_io_cycle_i,
	input wire logic        ext_wait_n_i,
	input wire logic        bus_takeover_request_n_i,
	// design outputs
	input wire logic        cpu_stall_o,
	input wire logic        bus_grant_n_o,
	input wire logic        addr_oe_o,
	input wire logic [3:0]  select_line_n_o,
	input wire logic        memory_request_n_o,
	input wire logic        port_request_n_o,
	input wire logic        rd_n_o,
	input wire logic        wr_n_o
);
	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);
	// takeover steps
	sequence s_take;
		$fell(bus_takeover_request_n_i);
	endsequence
	sequence s_granted;
		!bus_grant_n_o && !addr_oe_o;
	endsequence
	a_one_select: assert property ($countones(~select_line_n_o) <= 1)
		else $error("two selects low");
	a_idle_high: assert property (!cpu_mem_cycle_i && !cpu_io_cycle_i
		|-> &select_line_n_o) else $error("select without access");
	a_memory_request_n_src: assert property (!memory_request_n_o
		|-> cpu_mem_cycle_i && !(&select_line_n_o)) else $error("bad memory_request_n");
	a_port_src: assert property (!port_request_n_o
		|-> cpu_io_cycle_i && !(&select_line_n_o)) else $error("bad port_request_n");
	a_strobe_excl: assert property ((memory_request_n_o | port_request_n_o)
		&& (rd_n_o | wr_n_o)) else $error("strobes clash");
	a_peri_gap: assert property (cpu_io_cycle_i && bus_grant_n_o
		&& cpu_addr_i[15:7] == 9'h001 |-> &select_line_n_o)
		else $error("select in peripheral range");
	a_wait_hold: assert property (cpu_stall_o && !ext_wait_n_i ##1
		(cpu_mem_cycle_i || cpu_io_cycle_i) |-> cpu_stall_o)
		else $error("stall dropped while wait low");
	a_grant_take: assert property (s_take |-> ##[1:40] s_granted)
		else $error("no grant");
	a_addr_free: assert property (!bus_grant_n_o |-> !addr_oe_o)
		else $error("address driven while granted");
endmodule : cswb_monitor
`default_nettype wire

// ### verification/cswb_ext_model.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// external memory behind the selects
// ----
module cswb_ext_model (
	// clock
	input  wire logic        sys_clk_i,
	// bus from the controller
	input  wire logic [23:0] addr_i,
	input  wire logic [3:0]  select_line_n_i,
	input  wire logic        rd_n_i,
	input  wire logic [3:0]  hold_i,
	// answers
	output logic [7:0]       data_o,
	output logic             wait_n_o
);
	logic       on;
	logic [3:0] cnt = 4'h0;
	logic [7:0] junk = 8'h00;
	// released bus toggles so a stale byte never passes
	assign on = !(&select_line_n_i) && !rd_n_i;
	assign data_o = on ? addr_i[7:0] ^ 8'h5a : junk;
	// pull one cycle late, the input is sampled
	assign wait_n_o = !(on && cnt != 4'h0 && cnt <= hold_i);
	// count cycles of the selected read
	always_ff @(posedge sys_clk_i) begin
		junk <= ~junk ^ 8'h21;
		cnt  <= on ? cnt + {3'h0, cnt != 4'hf} : 4'h0;
	end
endmodule : cswb_ext_model
`default_nettype wire

// ### verification/chip_select_wait_bus_ctrl_test.sv
`timescale 1ns/10ps
`default_nettype none
// ----
// self-checking bench
// ----
module chip_select_wait_bus_ctrl_test;
	import cswb_pkg::*;
	logic        clk, rst, awv, wv, bry, arv, rry, cm, ci, crd, cwr;
	logic        tk_n, rl, awr, wrd, bv, arr, rv, stall, gnt_n, oe;
	logic        mrq_n, prq_n, rdn, wrn, wn;
	logic [1:0]  br, rr;
	logic [3:0]  hold, sel_n;
	logic [7:0]  awa, ara, snap, s1, crdat, ed;
	logic [23:0] ca, ea, ba;
	logic [31:0] wd, rnd, rdat, err_count, n_tests;
	logic [33:0] exp_q[$];
	int          cnt, c1, c2;
	// memory entries first, then io entries
	logic [23:0] ta [12] = '{24'h000000, 24'h7f0000, 24'h800000,
		24'h9f0000, 24'ha00000, 24'ha10000, 24'hd00000, 24'h000042,
		24'h00007f, 24'h000080, 24'h0000ff, 24'h000100};
	logic [3:0]  te [12] = '{4'he, 4'he, 4'hd, 4'hd, 4'hb, 4'hf, 4'hf,
		4'h7, 4'h7, 4'hf, 4'hf, 4'hf};
	// address on the wires follows whoever owns the bus
	assign ba = oe ? ca : ea;
	cswb_ctrl u_dut (.sys_clk_i(clk), .rst_i(rst),
		.s_axi_awvalid_i(awv), .s_axi_awready_o(awr), .s_axi_awaddr_i(awa),
		.s_axi_wvalid_i(wv), .s_axi_wready_o(wrd), .s_axi_wdata_i(wd),
		.s_axi_wstrb_i(4'h1), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
		.s_axi_bresp_o(br), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
		.s_axi_araddr_i(ara), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
		.s_axi_rdata_o(rdat), .s_axi_rresp_o(rr), .cpu_addr_i(ca),
		.cpu_mem_cycle_i(cm), .cpu_io_cycle_i(ci), .cpu_rd_i(crd),
		.cpu_wr_i(cwr), .cpu_stall_o(stall), .cpu_rdata_o(crdat),
		.ext_addr_i(ea), .ext_data_i(ed), .ext_wait_n_i(wn),
		.bus_takeover_request_n_i(tk_n), .bus_grant_n_o(gnt_n),
		.addr_oe_o(oe), .select_line_n_o(sel_n),
		.memory_request_n_o(mrq_n), .port_request_n_o(prq_n),
		.rd_n_o(rdn), .wr_n_o(wrn));
	cswb_ext_model u_mem (.sys_clk_i(clk), .addr_i(ba),
		.select_line_n_i(sel_n), .rd_n_i(rdn), .hold_i(hold),
		.data_o(ed), .wait_n_o(wn));
	task chk(input logic [33:0] s, input logic [33:0] e);
		n_tests = n_tests + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("BAD %0t seen %h exp %h", $time, s, e);
		end
	endtask : chk
	task stop_test;
		$display("errors %0d checks %0d", err_count, n_tests);
		if (err_count == 0 && n_tests > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask : stop_test
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
		logic ad, dd;
		{ad, dd} = 2'h0;
		@(posedge clk);
		{awv, wv, bry} <= 3'h7;
		awa <= a;
		wd  <= d;
		while (!(ad && dd)) begin
			@(posedge clk);
			ad = ad | awr;
			dd = dd | wrd;
			awv <= !ad;
			wv  <= !dd;
		end
		do @(posedge clk); while (!bv);
		bry <= 0;
		chk(br, r);
	endtask : wr
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		@(posedge clk);
		{arv, rry} <= 2'h3;
		ara <= a;
		exp_q.push_back({r, e});
		do @(posedge clk); while (!arr);
		arv <= 0;
		do @(posedge clk); while (!rv);
		rry <= 0;
	endtask : rd
	task cfg(input logic [3:0] n, input logic [7:0] c, lo, hi);
		wr({n, 4'h0}, {24'h0, c}, CSWB_RESP_OK);
		wr({n, 4'h4}, {24'h0, lo}, CSWB_RESP_OK);
		wr({n, 4'h8}, {24'h0, hi}, CSWB_RESP_OK);
	endtask : cfg
	// one cpu access held until the stall ends
	task acc(input logic io, w, input logic [23:0] a);
		@(posedge clk);
		{cm, ci, crd, cwr} <= {!io, io, !w, w};
		ca <= a;
		@(negedge clk);
		snap = {sel_n, mrq_n, prq_n, rdn, wrn};
		rl = !rdn;
		cnt = 0;
		while (stall && cnt < 99) begin
			@(negedge clk);
			cnt++;
			rl = rl | !rdn;
			if (cnt == 1)
				s1 = {sel_n, mrq_n, prq_n, rdn, wrn};
		end
		if (cnt >= 99) chk(stall, 1'b0);
		@(posedge clk);
		{cm, ci, crd, cwr} <= 4'h0;
		@(negedge clk);
	endtask : acc
	// clock
	initial begin
		clk = 0;
		forever #10 clk = ~clk;
	end
	// hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count = err_count + 1;
		stop_test;
	end
	// each read answer against the oldest note
	always @(posedge clk) if (rv && rry) chk({rr, rdat}, exp_q.pop_front());
	// main sequence
	initial begin
		{awv, wv, bry, arv, rry, cm, ci, crd, cwr, awa, ara, wd} = '0;
		{ca, ea, hold, err_count, n_tests} = '0;
		{tk_n, rst} = 2'h3;
		rnd = $urandom(32'h5023);
		repeat (2) @(posedge clk);
		rst <= 0;
		for (int n = 0; n < 4; n++) begin
			rd({n[3:0], 4'h0}, 0, CSWB_RESP_OK);
			rd({n[3:0], 4'h4}, 0, CSWB_RESP_OK);
			rd({n[3:0], 4'h8}, n == 0 ? 32'hff : 32'h0, CSWB_RESP_OK);
		end
		rd(8'h44, 0, CSWB_RESP_ERR);
		wr(8'h44, 1, CSWB_RESP_ERR);
		// select 0 covers all but is still disabled
		acc(0, 0, 24'h123456);
		chk(snap[7:4], 4'hf);
		cfg(0, 8'h28, 8'h00, 8'h7f);
		cfg(1, 8'h28, 8'h00, 8'h9f);
		cfg(2, 8'h28, 8'ha0, 8'ha0);
		cfg(3, 8'h38, 8'h00, 8'h00);
		for (int i = 0; i < 12; i++) begin
			rnd = $urandom;
			acc(i > 6, i[0], i > 6 ? {rnd[7:0], ta[i][15:0]}
				: {ta[i][23:16], rnd[15:0]});
			if (&te[i])
				chk(snap[7:4], 4'hf);
			else
				chk(snap, {te[i], i > 6, i < 7, i[0], !i[0]});
			if (!i[0] && !(&te[i])) chk(crdat, ca[7:0] ^ 8'h5a);
		end
		// seven programmed waits against one
		acc(0, 0, 24'h000010);
		c1 = cnt;
		wr(8'h00, 32'he8, CSWB_RESP_OK);
		acc(0, 0, 24'h000010);
		c2 = cnt;
		chk(34'(c2 - c1), 34'd6);
		hold <= 4'hc;
		acc(0, 0, 24'h000020);
		chk(cnt > c2 + 3, 1);
		chk(crdat, 8'h7a);
		// legacy read: select alone first, strobes later
		// two clocks per state, so the sampled wait lands inside T2
		wr(8'h0c, 32'h21, CSWB_RESP_OK);
		hold <= 4'h3;
		acc(0, 0, 24'h000030);
		chk({s1, rl}, {8'hef, 1'b1});
		chk(cnt > 7, 1);
		chk(crdat, 8'h6a);
		rnd = $urandom;
		wr(8'h38, rnd, CSWB_RESP_OK);
		rd(8'h38, {24'h0, rnd[7:0]}, CSWB_RESP_OK);
		// takeover keeps decoding the outside address
		tk_n <= 0;
		ea   <= 24'ha05555;
		cnt = 0;
		while (gnt_n && cnt < 50) begin
			@(posedge clk);
			cnt++;
		end
		chk({gnt_n, oe}, 0);
		acc(0, 0, 24'h000000);
		chk(snap[7:4], 4'hb);
		tk_n <= 1;
		stop_test;
	end
endmodule : chip_select_wait_bus_ctrl_test
bind cswb_ctrl cswb_monitor u_mon (.*);
`default_nettype wire
